// *** pkg/scp_pkg.sv ***
// constants, types and config carriers for the security coprocessor pin logic
// assumes one 100 MHz system clock; all pins arrive asynchronous to it
package scp_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_MHZ = 100; // system clock rate
  localparam int WD_TIMEOUT_US = 1000; // host-alive window, plain default
  localparam int WD_TIMEOUT_CYC_DEF = WD_TIMEOUT_US * CLK_MHZ; // window in cycles
  localparam int WD_CNT_W = 24; // watchdog counter width
  localparam int SPI_MAX_KHZ = 10000; // fastest serial clock supported

  // ************************************************************
  // widths and layouts
  // ************************************************************
  localparam int BYTE_W = 8; // spi word
  localparam int BIT_CNT_W = 3; // bit index in a byte
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7; // eighth sampling edge
  localparam logic [BIT_CNT_W-1:0] BIT_ONE = 3'h1; // bit counter step
  localparam int FIFO_DEPTH = 16; // command bytes buffered
  localparam logic [BYTE_W-1:0] IDLE_TX_BYTE = 8'h00; // sent when no response
  localparam int KEY_W = 8; // zeroizable key groups
  localparam int DUR_W = 16; // event drive length, in cycles
  localparam logic [DUR_W-1:0] DUR_ONE = 16'h0001; // duration step

  // pin sync vector layout
  localparam int PIN_W = 6;
  localparam int PIN_PD = 0;
  localparam int PIN_INTR = 1;
  localparam int PIN_WDI = 2;
  localparam int PIN_SCK = 3;
  localparam int PIN_SS = 4;
  localparam int PIN_MOSI = 5;
  localparam logic [PIN_W-1:0] SYNC_RST = 6'h12; // intrusion and select idle high

  // event source positions
  localparam int EVT_W = 6;
  localparam int EVT_BOOT = 0; // secure boot result
  localparam int EVT_CHAN = 1; // secure channel result
  localparam int EVT_INTR = 2; // intrusion detected
  localparam int EVT_CONS = 3; // consistency error
  localparam int EVT_POR = 4; // power-on reset
  localparam int EVT_WDOG = 5; // watchdog expiry

  // ************************************************************
  // types
  // ************************************************************
  typedef struct packed {
    logic en; // event pin function enabled
    logic pulse; // 1: timed pulse, 0: level until cleared
    logic level; // level driven while active
    logic [EVT_W-1:0] sel; // sources that trigger
    logic [DUR_W-1:0] dur; // pulse length in cycles
  } scp_evt_cfg_t;

  typedef struct packed {
    logic en; // intrusion detection enabled
    logic [KEY_W-1:0] keysel; // key groups erased on intrusion
  } scp_intr_cfg_t;

  typedef enum logic [2:0] {
    st_off,
    st_boot,
    st_idle,
    st_busy,
    st_resp
  } scp_state_t;

endpackage

// *** verilog/scp_fifo.sv ***
// synchronous fifo for received command bytes
// assumes one clock; clear empties and wipes every entry
`timescale 1ns/1ps
module scp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);

  // ************************************************************
  // pointers
  // ************************************************************
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_ff [DEPTH]; // storage
  logic [AW:0] wr_ff; // write pointer, extra wrap bit
  logic [AW:0] rd_ff; // read pointer, extra wrap bit
  wire full = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
  wire empty = (wr_ff == rd_ff);
  wire push = in_valid_i & ~full;
  wire pop = out_ready_i & ~empty;

  assign in_ready_o = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o = mem_ff[rd_ff[AW-1:0]];

  // pointer advance; clear wins so wiped data is never read
  always_ff @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= (AW+1)'(wr_ff + {{AW{1'b0}}, push});
      rd_ff <= (AW+1)'(rd_ff + {{AW{1'b0}}, pop});
    end
  end

  // ************************************************************
  // entries
  // ************************************************************
  // each entry erased on clear, so no stale command survives
  for (genvar g = 0; g < DEPTH; g++) begin : g_ent
    always_ff @(posedge clk_i) begin
      if (rst_i || clr_i) begin
        mem_ff[g] <= '0;
      end else if (push && (wr_ff[AW-1:0] == AW'(g))) begin
        mem_ff[g] <= in_data_i;
      end
    end
  end

endmodule // scp_fifo

// *** verilog/scp_ctrl.sv ***
// pin control logic of the security coprocessor: power-down, intrusion,
// event pin, watchdog, ready, and spi byte transport into a command fifo
// assumes the command engine drains cmd_* and feeds resp_*; pins are async
`timescale 1ns/1ps
module scp_ctrl
  import scp_pkg::*;
#(
  parameter int unsigned WD_TIMEOUT_CYC = WD_TIMEOUT_CYC_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic power_down_input_n_i,
  input wire logic intrusion_n_i,
  input wire logic host_alive_input_i,
  input wire logic serial_clock_pin_i,
  input wire logic slave_select_pin_n_i,
  input wire logic serial_data_in_pin_i,
  output logic serial_data_out_pin_o,
  output logic serial_data_out_oe_n_o,
  output logic ready_o,
  output logic event_pin_o,
  output logic event_oe_n_o,
  output logic intr_pullup_en_o,
  input wire logic boot_done_i,
  input wire logic proc_done_i,
  input wire logic cond_ok_i,
  input wire scp_intr_cfg_t intr_cfg_i,
  input wire scp_evt_cfg_t evt_cfg_i,
  input wire logic evt_clr_i,
  input wire logic [EVT_W-1:0] evt_src_i,
  input wire logic wd_en_i,
  output logic zeroize_o,
  output logic [KEY_W-1:0] key_zeroize_o,
  output logic intr_evt_o,
  output logic wd_expire_o,
  output logic [BYTE_W-1:0] cmd_data_o,
  output logic cmd_valid_o,
  input wire logic cmd_ready_i,
  input wire logic [BYTE_W-1:0] resp_data_i,
  input wire logic resp_valid_i,
  output logic resp_ready_o,
  output logic overrun_o,
  input wire logic overrun_clr_i
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [PIN_W-1:0] meta_ff; // first stage, read only by sync_ff
  logic [PIN_W-1:0] sync_ff; // second stage, safe to use
  logic [PIN_W-1:0] sync_d_ff; // delayed copy for edge detect
  wire [PIN_W-1:0] pins_raw = {serial_data_in_pin_i, slave_select_pin_n_i,
                               serial_clock_pin_i, host_alive_input_i,
                               intrusion_n_i, power_down_input_n_i};

  // two flops per pin, then one more for edges
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= SYNC_RST;
      sync_ff <= SYNC_RST;
      sync_d_ff <= SYNC_RST;
    end else begin
      meta_ff <= pins_raw;
      sync_ff <= meta_ff;
      sync_d_ff <= sync_ff;
    end
  end

  wire pd_n_s = sync_ff[PIN_PD]; // high: awake
  wire intr_n_s = sync_ff[PIN_INTR];
  wire mosi_s = sync_ff[PIN_MOSI];
  wire ss_n_s = sync_ff[PIN_SS];
  wire sck_rise = sync_ff[PIN_SCK] & ~sync_d_ff[PIN_SCK];
  wire sck_fall = ~sync_ff[PIN_SCK] & sync_d_ff[PIN_SCK];
  wire ss_fall = ~sync_ff[PIN_SS] & sync_d_ff[PIN_SS];
  wire ss_rise = sync_ff[PIN_SS] & ~sync_d_ff[PIN_SS];
  wire wdi_toggle = sync_ff[PIN_WDI] ^ sync_d_ff[PIN_WDI];

  // ************************************************************
  // power and command state
  // ************************************************************
  scp_state_t state_ff; // power/command state
  scp_state_t nxt_state;
  logic got_byte_ff; // frame carried at least one byte
  logic fifo_in_ready; // command fifo has room
  logic zero_ff; // volatile wipe pulse

  wire spi_on = (state_ff == st_idle) || (state_ff == st_busy) || (state_ff == st_resp);
  wire frame_act = ~ss_n_s & spi_on;
  wire frame_end = ss_rise & spi_on;

  // next state; power-down overrides everything
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      st_off: if (pd_n_s) nxt_state = st_boot;
      st_boot: if (boot_done_i) nxt_state = st_idle;
      st_idle: if (frame_end && got_byte_ff) nxt_state = st_busy;
      st_busy: if (proc_done_i) nxt_state = st_resp;
      st_resp: if (frame_end) nxt_state = st_idle;
    endcase
    if (!pd_n_s) begin
      nxt_state = st_off;
    end
  end

  // reset starts asleep, so boot is always run first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= st_off;
      zero_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      zero_ff <= (nxt_state == st_off) && (state_ff != st_off);
    end
  end

  // a full fifo also means a new command cannot be taken
  assign ready_o = ((state_ff == st_idle) && fifo_in_ready) || (state_ff == st_resp);
  assign zeroize_o = zero_ff;
  wire fifo_clr = (state_ff == st_off) || (state_ff == st_boot);

  // ************************************************************
  // spi slave, mode 0 and mode 3
  // ************************************************************
  logic [BYTE_W-1:0] rx_ff; // incoming shift register
  logic [BYTE_W-1:0] tx_ff; // outgoing shift register
  logic [BIT_CNT_W-1:0] bitcnt_ff; // rising edges seen in byte
  logic armed_ff; // a rising edge seen this frame
  logic ovr_ff; // byte lost to full fifo

  wire [BYTE_W-1:0] nxt_rx = {rx_ff[BYTE_W-2:0], mosi_s};
  wire rx_push = frame_act & sck_rise & (bitcnt_ff == LAST_BIT);
  // mode 3 opens with a falling edge; armed_ff makes it harmless
  wire tx_load = frame_act & (ss_fall | (sck_fall & armed_ff & (bitcnt_ff == '0)));
  wire tx_shift = frame_act & sck_fall & armed_ff & (bitcnt_ff != '0);
  wire [BYTE_W-1:0] tx_byte = resp_valid_i ? resp_data_i : IDLE_TX_BYTE;

  // sample on rising serial clock
  always_ff @(posedge clk_i) begin
    if (rst_i || !frame_act) begin
      bitcnt_ff <= '0;
      armed_ff <= 1'b0;
      rx_ff <= '0;
    end else if (sck_rise) begin
      rx_ff <= nxt_rx;
      bitcnt_ff <= BIT_CNT_W'(bitcnt_ff + BIT_ONE);
      armed_ff <= 1'b1;
    end
  end

  // shift out on falling serial clock, reload at byte boundary
  always_ff @(posedge clk_i) begin
    if (rst_i || (state_ff == st_off)) begin
      tx_ff <= '0;
    end else if (tx_load) begin
      tx_ff <= tx_byte;
    end else if (tx_shift) begin
      tx_ff <= {tx_ff[BYTE_W-2:0], 1'b0};
    end
  end

  // frame byte flag and overrun; set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i || (state_ff == st_off)) begin
      got_byte_ff <= 1'b0;
      ovr_ff <= 1'b0;
    end else begin
      got_byte_ff <= rx_push | (got_byte_ff & ~ss_fall);
      ovr_ff <= (rx_push & ~fifo_in_ready) | (ovr_ff & ~overrun_clr_i);
    end
  end

  assign serial_data_out_pin_o = tx_ff[BYTE_W-1];
  assign serial_data_out_oe_n_o = ~frame_act; // released outside a frame
  assign resp_ready_o = tx_load; // a valid response byte is taken here
  assign overrun_o = ovr_ff;

  scp_fifo #(
    .W(BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) scp_fifo_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(fifo_clr),
    .in_data_i(nxt_rx),
    .in_valid_i(rx_push),
    .in_ready_o(fifo_in_ready),
    .out_data_o(cmd_data_o),
    .out_valid_o(cmd_valid_o),
    .out_ready_i(cmd_ready_i)
  );

  // ************************************************************
  // intrusion
  // ************************************************************
  logic intr_act_d_ff; // previous qualified intrusion level
  logic intr_evt_ff; // one-cycle intrusion event
  logic [KEY_W-1:0] key_zero_ff; // key groups to erase

  // only counts while awake and operating conditions hold
  wire intr_act = ~intr_n_s & intr_cfg_i.en & pd_n_s & cond_ok_i
                  & (state_ff != st_off);
  wire intr_new = intr_act & ~intr_act_d_ff;

  // event on the start of each qualified low period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      intr_act_d_ff <= 1'b0;
      intr_evt_ff <= 1'b0;
      key_zero_ff <= '0;
    end else begin
      intr_act_d_ff <= intr_act;
      intr_evt_ff <= intr_new;
      key_zero_ff <= intr_new ? intr_cfg_i.keysel : '0;
    end
  end

  assign intr_pullup_en_o = 1'b1;
  assign intr_evt_o = intr_evt_ff;
  assign key_zeroize_o = key_zero_ff;

  // ************************************************************
  // watchdog
  // ************************************************************
  localparam logic [WD_CNT_W-1:0] WD_LAST = WD_CNT_W'(WD_TIMEOUT_CYC - 1);
  logic [WD_CNT_W-1:0] wd_cnt_ff; // cycles since last host toggle
  logic wd_exp_ff; // expiry pulse
  wire wd_run = wd_en_i & (state_ff != st_off);
  wire wd_hit = wd_run & ~wdi_toggle & (wd_cnt_ff == WD_LAST);

  // restart on each toggle, restart after expiry too
  always_ff @(posedge clk_i) begin
    if (rst_i || !wd_run || wdi_toggle || wd_hit) begin
      wd_cnt_ff <= '0;
    end else begin
      wd_cnt_ff <= WD_CNT_W'(wd_cnt_ff + 1'b1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_exp_ff <= 1'b0;
    end else begin
      wd_exp_ff <= wd_hit;
    end
  end

  assign wd_expire_o = wd_exp_ff;

  // ************************************************************
  // event pin
  // ************************************************************
  logic por_pend_ff; // high for one cycle after reset
  logic [EVT_W-1:0] evt_int; // internally raised sources
  logic drive_ff; // pin actively driven
  logic pol_ff; // level being driven
  logic [DUR_W-1:0] evt_cnt_ff; // remaining drive cycles

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      por_pend_ff <= 1'b1;
    end else begin
      por_pend_ff <= 1'b0;
    end
  end

  // gather internal sources into their slots
  always_comb begin
    evt_int = '0;
    evt_int[EVT_INTR] = intr_evt_ff;
    evt_int[EVT_POR] = por_pend_ff;
    evt_int[EVT_WDOG] = wd_exp_ff;
  end

  wire evt_hit = |((evt_src_i | evt_int) & evt_cfg_i.sel);
  wire evt_trig = evt_cfg_i.en & evt_hit;
  wire evt_last = (evt_cnt_ff <= DUR_ONE);

  // retrigger restarts the drive; a zero duration still gives one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i || !evt_cfg_i.en) begin
      drive_ff <= 1'b0;
      pol_ff <= 1'b1;
      evt_cnt_ff <= '0;
    end else if (evt_trig) begin
      drive_ff <= 1'b1;
      pol_ff <= evt_cfg_i.level;
      evt_cnt_ff <= evt_cfg_i.dur;
    end else if (drive_ff && evt_cfg_i.pulse) begin
      drive_ff <= ~evt_last;
      evt_cnt_ff <= evt_last ? '0 : DUR_W'(evt_cnt_ff - DUR_ONE);
    end else if (drive_ff && evt_clr_i) begin
      drive_ff <= 1'b0;
    end
  end

  assign event_pin_o = pol_ff;
  assign event_oe_n_o = ~drive_ff;

  // ************************************************************
  // checks
  // ************************************************************
  logic [DUR_W-1:0] drv_len_ff; // cycles driven since trigger
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drv_len_ff <= '0;
    end else if (evt_trig) begin
      drv_len_ff <= '0;
    end else if (drive_ff) begin
      drv_len_ff <= DUR_W'(drv_len_ff + DUR_ONE);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence frame_cmd_s;
    frame_end && got_byte_ff && (state_ff == st_idle) && pd_n_s;
  endsequence
  sequence busy_done_s;
    (state_ff == st_busy) && proc_done_i && pd_n_s;
  endsequence

  pd_wipe_a: assert property ($fell(pd_n_s) && (state_ff != st_off) |=> zeroize_o ##1 !cmd_valid_o)
    else $error("power-down did not wipe volatile data");
  pd_ready_low_a: assert property (!pd_n_s |=> !ready_o)
    else $error("ready high while powered down");
  intr_fire_a: assert property (intr_new |=> intr_evt_o && (key_zeroize_o == $past(intr_cfg_i.keysel)))
    else $error("intrusion response missing or wrong keys");
  intr_gate_a: assert property (intr_evt_o |-> $past(intr_cfg_i.en) && $past(pd_n_s) && $past(cond_ok_i))
    else $error("intrusion event while not qualified");
  evt_release_a: assert property (!evt_cfg_i.en |=> event_oe_n_o)
    else $error("event pin driven while disabled");
  evt_drive_a: assert property (evt_trig |=> !event_oe_n_o && (event_pin_o == $past(evt_cfg_i.level)))
    else $error("event pin not driven at configured level");
  evt_len_a: assert property ($fell(drive_ff) && $past(evt_cfg_i.en) && $past(evt_cfg_i.pulse)
                              && ($past(evt_cfg_i.dur) != '0) |-> drv_len_ff == $past(evt_cfg_i.dur))
    else $error("event pulse length wrong");
  wd_off_a: assert property (!wd_en_i |=> !wd_expire_o)
    else $error("watchdog expired while disabled");
  wd_bound_a: assert property (wd_run && !wdi_toggle && (wd_cnt_ff == WD_LAST) |=> wd_expire_o && (wd_cnt_ff == '0))
    else $error("watchdog window not enforced");
  boot_ready_a: assert property ((state_ff == st_boot) && boot_done_i && pd_n_s |=> ready_o)
    else $error("ready not raised after boot");
  cmd_busy_a: assert property (frame_cmd_s |=> !ready_o)
    else $error("ready high while command processed");
  resp_ready_a: assert property (busy_done_s |=> ready_o)
    else $error("ready not raised for response");
  spi_byte_a: assert property (frame_act && sck_rise && (bitcnt_ff == LAST_BIT) && fifo_in_ready
                               && !cmd_valid_o |=> cmd_valid_o && (cmd_data_o == $past(nxt_rx)))
    else $error("received spi byte not queued");

endmodule // scp_ctrl

// *** dv/scp_host_model.sv ***
// host side spi master model: mode 0 or mode 3, sck period of 8 clk
// assumes the bench resolves the miso wire before it reaches us
`timescale 1ns/1ps
module scp_host_model (
  input wire logic clk_i,
  input wire logic miso_i,
  output logic sck_o,
  output logic ss_n_o,
  output logic mosi_o
);
  // **********
  // frame task
  // **********
  // idle: deselected, sck low
  initial begin
    sck_o = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  logic cpol = 1'b0; // clock idle level: 0 for mode 0, 1 for mode 3
  // change clock polarity only while deselected, then let it settle
  task automatic set_mode(input logic pol);
    cpol = pol;
    sck_o <= pol;
    repeat (4) @(posedge clk_i);
  endtask
  // one byte each way, msb first; sck stands still outside frames
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    ss_n_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    for (int i = 7; i >= 0; i--) begin
      mosi_o <= tx[i];
      if (cpol) sck_o <= 1'b0; // mode 3: the leading fall launches each bit
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b1;
      rx[i] = miso_i;
      repeat (4) @(posedge clk_i);
      if (!cpol) sck_o <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    ss_n_o <= 1'b1;
    mosi_o <= ~tx[0]; // no stale bit once deselected
    repeat (8) @(posedge clk_i);
  endtask
endmodule // scp_host_model

// *** dv/scp_ctrl_test.sv ***
// bench for scp_ctrl: pins, ready, spi into the fifo, events
// assumes the host model drives spi; pulses counted on negedge
`timescale 1ns/1ps
module scp_ctrl_test import scp_pkg::*;;
  logic clk_i = 0, rst_i = 1, pd_n = 0, intr_n = 1, alive = 0, boot = 0;
  logic pdone = 0, cond = 1, eclr = 0, wden = 0, cready = 0, rvalid = 0;
  logic oclr = 0, miso_last = 0;
  logic [EVT_W-1:0] esrc = '0;
  logic [7:0] rdata = '0, kz, cdata, rx, kz_seen;
  scp_intr_cfg_t icfg = '0;
  scp_evt_cfg_t ecfg = '0;
  logic miso_d, miso_oe_n, rdy, epin, eoe_n, pull, zer, iev, wdx, cvalid, rready, ovr;
  logic sck, ss_n, mosi;
  int failures = 0, comparisons = 0, c_int = 0, c_wd = 0, c_zer = 0, c_drv = 0, c_low = 0;
  int c_rrdy = 0; // response bytes taken by the link
  int s0, s1, s2, k;
  wire miso_w = miso_oe_n ? ~miso_last : miso_d; // released: inverse of last
  wire evt_w = eoe_n ? 1'b1 : epin; // external pull-up
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (!miso_oe_n) miso_last <= miso_d;
  // pulse counters, sampled where outputs are settled
  always @(negedge clk_i) begin
    if (iev === 1'b1) begin
      c_int++;
      kz_seen = kz;
    end
    if (wdx === 1'b1) c_wd++;
    if (zer === 1'b1) c_zer++;
    if (eoe_n === 1'b0) c_drv++;
    if (evt_w === 1'b0) c_low++;
    if (rready === 1'b1) c_rrdy++;
  end
  scp_ctrl #(.WD_TIMEOUT_CYC(64)) scp_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i),
    .power_down_input_n_i(pd_n), .intrusion_n_i(intr_n), .host_alive_input_i(alive),
    .serial_clock_pin_i(sck), .slave_select_pin_n_i(ss_n), .serial_data_in_pin_i(mosi),
    .serial_data_out_pin_o(miso_d), .serial_data_out_oe_n_o(miso_oe_n), .ready_o(rdy),
    .event_pin_o(epin), .event_oe_n_o(eoe_n), .intr_pullup_en_o(pull),
    .boot_done_i(boot), .proc_done_i(pdone), .cond_ok_i(cond), .intr_cfg_i(icfg),
    .evt_cfg_i(ecfg), .evt_clr_i(eclr), .evt_src_i(esrc), .wd_en_i(wden),
    .zeroize_o(zer), .key_zeroize_o(kz), .intr_evt_o(iev), .wd_expire_o(wdx),
    .cmd_data_o(cdata), .cmd_valid_o(cvalid), .cmd_ready_i(cready),
    .resp_data_i(rdata), .resp_valid_i(rvalid), .resp_ready_o(rready),
    .overrun_o(ovr), .overrun_clr_i(oclr));
  scp_host_model scp_host_model_inst (.clk_i(clk_i), .miso_i(miso_w), .sck_o(sck),
    .ss_n_o(ss_n), .mosi_o(mosi));
  // **********
  // helpers
  // **********
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task summarize;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // **********
  // scenarios
  // **********
  // off while reset is still asserted, pins released
  task t_reset;
    check("ready", rdy, 0);
    check("evt oe", eoe_n, 1);
    check("evt wire", evt_w, 1);
    check("miso oe", miso_oe_n, 1);
    check("pullup", pull, 1);
  endtask
  // command byte in, response byte out, ready through busy
  task t_spi;
    pd_n <= 1'b1;
    boot <= 1'b1;
    tick(10);
    check("ready boot", rdy, 1);
    rdata <= 8'h3C;
    rvalid <= 1'b1;
    s2 = c_rrdy;
    scp_host_model_inst.xfer(8'hA5, rx);
    rvalid <= 1'b0;
    check("miso byte", rx, 8'h3C);
    check("resp taken", c_rrdy - s2, 2);
    check("cmd byte", cdata, 8'hA5);
    check("ready busy", rdy, 0);
    pdone <= 1'b1;
    tick(1);
    pdone <= 1'b0;
    tick(3);
    check("ready resp", rdy, 1);
  endtask
  // fill past sixteen with the engine stalled, then drain
  task t_fifo;
    for (int i = 0; i < 16; i++) scp_host_model_inst.xfer(8'h10 + i[7:0], rx);
    check("idle byte", rx, IDLE_TX_BYTE);
    check("overrun", ovr, 1);
    cready <= 1'b1;
    k = 0;
    for (int n = 0; n < 40; n++) begin
      @(posedge clk_i);
      if (cvalid === 1'b1) begin
        check("fifo data", cdata, (k == 0) ? 8'hA5 : 8'h10 + k - 1);
        k++;
      end
    end
    cready <= 1'b0;
    check("fifo count", k, 16);
    oclr <= 1'b1;
    tick(1);
    oclr <= 1'b0;
    tick(2);
    check("overrun clr", ovr, 0);
  endtask
  // intrusion off, then on; pulse and level event drive
  task t_intr;
    s0 = c_int;
    intr_n <= 1'b0;
    ecfg <= '{en: 1'b1, pulse: 1'b1, level: 1'b0, sel: 6'h04, dur: 16'h0005};
    tick(10);
    check("intr off", c_int - s0, 0);
    check("evt idle", eoe_n, 1);
    s1 = c_drv;
    s2 = c_low;
    icfg <= '{en: 1'b1, keysel: 8'h5A};
    tick(20);
    check("intr on", c_int - s0, 1);
    check("keys", kz_seen, 8'h5A);
    check("pulse len", c_drv - s1, 5);
    check("pulse low", c_low - s2, 5);
    intr_n <= 1'b1;
    ecfg <= '{en: 1'b1, pulse: 1'b0, level: 1'b1, sel: 6'h02, dur: 16'h0005};
    tick(3);
    esrc <= 6'h02;
    tick(1);
    esrc <= 6'h00;
    tick(12);
    check("level oe", eoe_n, 0);
    check("level hi", epin, 1);
    eclr <= 1'b1;
    tick(1);
    eclr <= 1'b0;
    tick(2);
    check("level end", eoe_n, 1);
    // bad operating conditions mask a low pin until they recover
    s0 = c_int;
    cond <= 1'b0;
    intr_n <= 1'b0;
    tick(10);
    check("intr cond", c_int - s0, 0);
    cond <= 1'b1;
    tick(10);
    check("intr cond ok", c_int - s0, 1);
    intr_n <= 1'b1;
    tick(4);
  endtask
  // watchdog silent when off, fires once, kept quiet by toggles
  task t_wd;
    s0 = c_wd;
    tick(100);
    check("wd off", c_wd - s0, 0);
    wden <= 1'b1;
    tick(100);
    check("wd fire", c_wd - s0, 1);
    s0 = c_wd;
    for (int i = 0; i < 10; i++) begin
      alive <= ~alive;
      tick(20);
    end
    check("wd fed", c_wd - s0, 0);
    wden <= 1'b0;
  endtask
  // power-down wipes, blocks intrusion and spi
  task t_pd;
    scp_host_model_inst.set_mode(1'b1);
    rdata <= 8'hC3;
    rvalid <= 1'b1;
    s2 = c_rrdy;
    scp_host_model_inst.xfer(8'h77, rx);
    rvalid <= 1'b0;
    check("miso m3", rx, 8'hC3);
    check("resp taken m3", c_rrdy - s2, 1);
    check("cmd m3", cdata, 8'h77);
    check("fifo kept", cvalid, 1);
    s0 = c_zer;
    s1 = c_int;
    pd_n <= 1'b0;
    tick(10);
    check("zeroize", c_zer - s0, 1);
    check("ready pd", rdy, 0);
    check("fifo wiped", cvalid, 0);
    intr_n <= 1'b0;
    tick(10);
    check("intr pd", c_int - s1, 0);
    scp_host_model_inst.xfer(8'h55, rx);
    check("spi pd", cvalid, 0);
  endtask
  // main sequence
  initial begin
    tick(3);
    t_reset;
    rst_i <= 1'b0;
    tick(3);
    t_spi;
    t_fifo;
    t_intr;
    t_wd;
    t_pd;
    summarize;
  end
  // hang guard
  initial begin
    #100000;
    failures++;
    summarize;
  end
endmodule // scp_ctrl_test
